//--- verilog/tic_pkg.sv
// Purpose: constants and types for the temperature indexed calibration loader
// Assumes: 50 MHz clock, byte-wide nonvolatile memory, 10-bit byte address
// Notes:   all register offsets are AHB-Lite byte addresses
package tic_pkg;

	// clock and refresh period
	localparam int          TIC_CLK_MHZ     = 50;
	localparam int          TIC_TICK_US     = 1000;
	localparam logic [15:0] TIC_TICK_CYCLES = 16'(TIC_TICK_US * TIC_CLK_MHZ);

	// lock codes
	localparam logic [7:0]  TIC_LOCKED_CODE   = 8'hFF;
	localparam logic [7:0]  TIC_UNLOCKED_CODE = 8'h00;

	// temperature index limits and span table split point
	localparam logic [7:0]  TIC_IDX_MIN   = 8'h00;
	localparam logic [7:0]  TIC_IDX_MAX   = 8'hAF;
	localparam logic [7:0]  TIC_IDX_SPLIT = 8'h80;

	// nonvolatile byte addresses (low byte of each word)
	localparam logic [9:0]  TIC_EE_OFF_TRIM_BASE = 10'h000;
	localparam logic [9:0]  TIC_EE_SETUP         = 10'h160;
	localparam logic [9:0]  TIC_EE_OFF_DRIFT     = 10'h164;
	localparam logic [9:0]  TIC_EE_SPAN_DRIFT    = 10'h168;
	localparam logic [9:0]  TIC_EE_LOCK          = 10'h16A;
	localparam logic [9:0]  TIC_EE_SPAN_LO_BASE  = 10'h200;
	localparam logic [9:0]  TIC_EE_SPAN_HI_BASE  = 10'h1A0;

	// load sequence: step 0 is the lock byte, then five words low/high
	localparam logic [3:0]  TIC_LAST_STEP = 4'hA;

	// setup register field
	localparam int          TIC_FB_SEL_BIT = 0;

	// bus register offsets
	localparam logic [7:0]  TIC_REG_STATUS     = 8'h00;
	localparam logic [7:0]  TIC_REG_SETUP      = 8'h04;
	localparam logic [7:0]  TIC_REG_OFF_DRIFT  = 8'h08;
	localparam logic [7:0]  TIC_REG_SPAN_DRIFT = 8'h0C;
	localparam logic [7:0]  TIC_REG_OFF_TRIM   = 8'h10;
	localparam logic [7:0]  TIC_REG_SPAN_TRIM  = 8'h14;

	// reset values
	localparam logic [15:0] TIC_CAL_RESET  = 16'h0000;
	localparam logic [7:0]  TIC_LOCK_RESET = 8'hFF;

	typedef struct packed {
		logic [15:0] setup;
		logic [15:0] offset_drift_coeff_reg;
		logic [15:0] span_drift_coeff_reg;
		logic [15:0] offset_trim_reg;
		logic [15:0] span_trim_reg;
	} tic_cal_type;

	typedef enum logic [4:0] {
		ST_POR     = 5'b00001,
		ST_IDLE    = 5'b00010,
		ST_CONVERT = 5'b00100,
		ST_READ    = 5'b01000,
		ST_WAIT    = 5'b10000
	} tic_state_type;

endpackage // tic_pkg

//--- verilog/tic_loader.sv
// Purpose: loads five calibration words from byte-wide nonvolatile memory when the lock byte reads locked and no override,
//          trim words through a clamped temperature index, refresh every 1 ms
// Assumes: single AHB-Lite master, whole-word transfers, memory answers each
//          read strobe with one valid pulse
// Notes:   bus writes to calibration words stand in for serial calibration
module tic_loader
	import tic_pkg::*;
#(
	parameter logic [15:0] TICK_CYCLES = TIC_TICK_CYCLES
)
(
	input  wire logic                clk,
	input  wire logic                srst,
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic                     hreadyout,
	output logic                     hresp,
	output logic [31:0]              hrdata,
	input  wire logic                por_done,
	input  wire logic                lock_override,
	output logic                     ee_rd,
	output logic [9:0]               ee_addr,
	input  wire logic [7:0]          ee_rdata,
	input  wire logic                ee_rvalid,
	output logic                     temp_start,
	input  wire logic [7:0]          temp_code,
	input  wire logic                temp_done,
	output tic_pkg::tic_cal_type     cal,
	output logic                     fb_internal_sel,
	output logic                     busy
);
	import tic_pkg::*;

	tic_state_type state;
	logic [15:0]   tick_cnt;
	logic          tick;
	logic          tick_pend;
	logic [7:0]    temp_idx;
	logic [7:0]    lock_byte;
	logic [3:0]    step;
	logic [7:0]    low_byte;
	logic          commit;
	logic          unlocked;
	logic          locked;
	logic          a_valid;
	logic          a_write;
	logic [7:0]    a_addr;
	logic          rd_wait;
	logic          bus_wr;
	logic [31:0]   next_hrdata;

	// clamp a raw reading to the table range
	function automatic logic [7:0] clamp_idx(input logic [7:0] raw);
		logic [7:0] r;
		r = raw;
		if (raw < TIC_IDX_MIN)
			r = TIC_IDX_MIN;
		if (raw > TIC_IDX_MAX)
			r = TIC_IDX_MAX;
		return r;
	endfunction

	// byte address of a load step; odd steps are low bytes
	function automatic logic [9:0] step_addr(input logic [3:0] s,
	                                         input logic [7:0] idx);
		logic [9:0] base;
		base = TIC_EE_LOCK;
		case (s)
			4'h1, 4'h2: base = TIC_EE_SETUP;
			4'h3, 4'h4: base = TIC_EE_OFF_DRIFT;
			4'h5, 4'h6: base = TIC_EE_SPAN_DRIFT;
			4'h7, 4'h8: base = TIC_EE_OFF_TRIM_BASE + {1'b0, idx, 1'b0};
			4'h9, 4'hA:
			begin
				if (idx < TIC_IDX_SPLIT)
					base = TIC_EE_SPAN_LO_BASE + {1'b0, idx, 1'b0};
				else
					base = TIC_EE_SPAN_HI_BASE + {2'b00, idx[6:0], 1'b0};
			end
			default: base = TIC_EE_LOCK;
		endcase
		// high byte sits at the odd neighbour
		if (s != 4'h0 && !s[0])
			return {base[9:1], 1'b1};
		return base;
	endfunction

	assign unlocked = (lock_byte == TIC_UNLOCKED_CODE) || lock_override;
	assign locked = (lock_byte == TIC_LOCKED_CODE) && !lock_override;

	// feedback resistor choice follows the setup word
	assign fb_internal_sel = cal.setup[TIC_FB_SEL_BIT];
	assign busy = (state == ST_CONVERT) || (state == ST_READ) ||
	              (state == ST_WAIT);

	// 1 ms timer, free running from reset
	always_ff @(posedge clk)
	begin
		if (srst)
			tick_cnt <= 16'h0000;
		else if (tick)
			tick_cnt <= 16'h0000;
		else
			tick_cnt <= tick_cnt + 16'h0001;
	end

	assign tick = (tick_cnt == TICK_CYCLES - 16'h0001);

	// a tick during a long load is kept, set wins over clear
	always_ff @(posedge clk)
	begin
		if (srst)
			tick_pend <= 1'b0;
		else if (tick)
			tick_pend <= 1'b1;
		else if (state == ST_IDLE)
			tick_pend <= 1'b0;
	end

	// load sequencer
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state      <= ST_POR;
			step       <= 4'h0;
			ee_rd      <= 1'b0;
			ee_addr    <= 10'h000;
			temp_start <= 1'b0;
		end
		else
		begin
			ee_rd      <= 1'b0;
			temp_start <= 1'b0;
			case (state)
				ST_POR:
				begin
					// wait for reset functions to finish
					if (por_done)
					begin
						state      <= ST_CONVERT;
						temp_start <= 1'b1;
					end
				end
				ST_IDLE:
				begin
					if (tick_pend)
					begin
						state      <= ST_CONVERT;
						temp_start <= 1'b1;
					end
				end
				ST_CONVERT:
				begin
					if (temp_done)
					begin
						state <= ST_READ;
						step  <= 4'h0;
					end
				end
				ST_READ:
				begin
					ee_rd   <= 1'b1;
					ee_addr <= step_addr(step, temp_idx);
					state   <= ST_WAIT;
				end
				ST_WAIT:
				begin
					if (ee_rvalid)
					begin
						if (step == 4'h0 && ee_rdata != TIC_LOCKED_CODE)
							state <= ST_IDLE;
						else if (step == 4'h0 && lock_override)
							state <= ST_IDLE;
						else if (step == TIC_LAST_STEP)
							state <= ST_IDLE;
						else
						begin
							step  <= step + 4'h1;
							state <= ST_READ;
						end
					end
				end
				default: state <= ST_POR;
			endcase
		end
	end

	// index sampled once per refresh, held for both lookups
	always_ff @(posedge clk)
	begin
		if (srst)
			temp_idx <= TIC_IDX_MIN;
		else if (state == ST_CONVERT && temp_done)
			temp_idx <= clamp_idx(temp_code);
	end

	// lock byte refreshed at the start of every load
	always_ff @(posedge clk)
	begin
		if (srst)
			lock_byte <= TIC_LOCK_RESET;
		else if (state == ST_WAIT && ee_rvalid && step == 4'h0)
			lock_byte <= ee_rdata;
	end

	// low byte staged until its partner arrives
	always_ff @(posedge clk)
	begin
		if (srst)
			low_byte <= 8'h00;
		else if (state == ST_WAIT && ee_rvalid && step[0])
			low_byte <= ee_rdata;
	end

	assign commit = (state == ST_WAIT) && ee_rvalid && (step != 4'h0) &&
	                !step[0];

	// AHB-Lite address phase capture
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			a_valid <= 1'b0;
			a_write <= 1'b0;
			a_addr  <= 8'h00;
			rd_wait <= 1'b0;
		end
		else if (hready)
		begin
			a_valid <= hsel && htrans[1];
			a_write <= hwrite;
			a_addr  <= haddr[7:0];
			rd_wait <= hsel && htrans[1] && !hwrite;
		end
		else
			rd_wait <= 1'b0;
	end

	// reads take one wait state so that hrdata comes from a flop
	assign hreadyout = !rd_wait;
	assign hresp     = 1'b0;
	assign bus_wr    = a_valid && a_write && hready;

	// calibration words: memory commits or serial (bus) writes
	always_ff @(posedge clk)
	begin
		if (srst)
			cal <= {5{TIC_CAL_RESET}};
		else if (commit)
		begin
			// word number follows the step pair
			case (step)
				4'h2: cal.setup <= {ee_rdata, low_byte};
				4'h4: cal.offset_drift_coeff_reg <= {ee_rdata, low_byte};
				4'h6: cal.span_drift_coeff_reg   <= {ee_rdata, low_byte};
				// table words, on every refresh too
				4'h8: cal.offset_trim_reg <= {ee_rdata, low_byte};
				4'hA: cal.span_trim_reg   <= {ee_rdata, low_byte};
				default: cal <= cal;
			endcase
		end
		else if (bus_wr && unlocked)
		begin
			// any 16-bit code accepted as is
			case (a_addr)
				TIC_REG_SETUP:      cal.setup <= hwdata[15:0];
				TIC_REG_OFF_DRIFT:  cal.offset_drift_coeff_reg <= hwdata[15:0];
				TIC_REG_SPAN_DRIFT: cal.span_drift_coeff_reg <= hwdata[15:0];
				TIC_REG_OFF_TRIM:   cal.offset_trim_reg <= hwdata[15:0];
				TIC_REG_SPAN_TRIM:  cal.span_trim_reg <= hwdata[15:0];
				default:            cal <= cal;
			endcase
		end
	end

	// read mux
	always_comb
	begin
		next_hrdata = 32'h0000_0000;
		case (a_addr)
			TIC_REG_STATUS:
				next_hrdata = {8'h00, temp_idx, lock_byte, 5'h00,
				               unlocked, locked, busy};
			TIC_REG_SETUP:      next_hrdata = {16'h0000, cal.setup};
			TIC_REG_OFF_DRIFT:
				next_hrdata = {16'h0000, cal.offset_drift_coeff_reg};
			TIC_REG_SPAN_DRIFT:
				next_hrdata = {16'h0000, cal.span_drift_coeff_reg};
			TIC_REG_OFF_TRIM:
				next_hrdata = {16'h0000, cal.offset_trim_reg};
			TIC_REG_SPAN_TRIM:
				next_hrdata = {16'h0000, cal.span_trim_reg};
			default:            next_hrdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			hrdata <= 32'h0000_0000;
		else if (rd_wait)
			hrdata <= next_hrdata;
	end

endmodule // tic_loader

//--- testbench/tic_loader_sva.sv
// Purpose: port checks for the calibration loader
// Assumes: one clock, srst synchronous active high
// Notes:   bound to every loader instance
module tic_loader_sva
	import tic_pkg::*;
(
	input wire logic        clk,
	input wire logic        srst,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        ee_rd,
	input wire logic [9:0]  ee_addr,
	input wire logic        ee_rvalid,
	input wire logic        temp_start,
	input wire logic        temp_done,
	input wire tic_cal_type cal,
	input wire logic        fb_internal_sel,
	input wire logic        busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	fb_select_a: assert property (
		fb_internal_sel == cal.setup[0])
		else $error("feedback select differs from setup bit");
	word_atomic_a: assert property (
		busy && !ee_rvalid && !hsel && !$past(hsel) |=> $stable(cal))
		else $error("word changed without a byte answer");
	rd_pulse_a: assert property (
		ee_rd |=> !ee_rd)
		else $error("read strobe longer than one cycle");
	pair_order_a: assert property (
		ee_rd && ee_addr[0] |-> ee_addr == $past(ee_addr) + 10'h001)
		else $error("high byte not right after its low byte");
	table_range_a: assert property (
		ee_rd |-> ee_addr <= 10'h16A || ee_addr >= 10'h1A0)
		else $error("read outside the table and word area");
	start_lock_a: assert property (
		temp_done && busy |-> ##[1:3] (ee_rd && ee_addr == 10'h16A))
		else $error("lock byte not read first");
	conv_pulse_a: assert property (
		temp_start |=> !temp_start && busy)
		else $error("conversion start not a pulse");
	read_wait_a: assert property (
		hsel && htrans[1] && !hwrite && hready |=> !hreadyout ##1 hreadyout)
		else $error("read data phase not one wait state");
endmodule // tic_loader_sva

bind tic_loader tic_loader_sva u_sva (.clk, .srst, .hsel, .htrans, .hwrite,
	.hready, .hreadyout, .ee_rd, .ee_addr, .ee_rvalid, .temp_start,
	.temp_done, .cal, .fb_internal_sel, .busy);

//--- testbench/tic_mem_model.sv
// Purpose: byte memory and temperature digitizer beside the loader
// Assumes: one answer per read strobe, LAT cycles later
// Notes:   read data toggles and temp_code holds the complement of temp_val when no answer stands
module tic_mem_model
#(
	parameter int LAT = 2
)
(
	input  wire logic       clk,
	input  wire logic [7:0] lock_val,
	input  wire logic [7:0] temp_val,
	input  wire logic       ee_rd,
	input  wire logic [9:0] ee_addr,
	output logic [7:0]      ee_rdata,
	output logic            ee_rvalid,
	input  wire logic       temp_start,
	output logic [7:0]      temp_code,
	output logic            temp_done
);
	timeunit 1ns;
	timeprecision 1ns;
	int rcnt = 0;
	int tcnt = 0;
	initial
	begin
		ee_rvalid = 1'b0;
		temp_done = 1'b0;
		ee_rdata = 8'h00;
		temp_code = 8'h00;
	end
	always @(posedge clk)
	begin
		ee_rvalid <= 1'b0;
		temp_done <= 1'b0;
		ee_rdata <= ~ee_rdata;
		temp_code <= ~temp_val;
		if (rcnt > 0)
			rcnt <= rcnt - 1;
		if (tcnt > 0)
			tcnt <= tcnt - 1;
		if (ee_rd)
			rcnt <= LAT;
		if (rcnt == 1)
		begin
			ee_rvalid <= 1'b1;
			ee_rdata <= (ee_addr == 10'h16A) ? lock_val :
				ee_addr[7:0] ^ {ee_addr[9:8], 6'h15};
		end
		if (temp_start)
			tcnt <= 3;
		if (tcnt == 1)
		begin
			temp_done <= 1'b1;
			temp_code <= temp_val;
		end
	end
endmodule // tic_mem_model

//--- testbench/tic_loader_bench.sv
// Purpose: self-checking bench for the calibration loader
// Assumes: refresh period shortened to 200 cycles
// Notes:   bus reads stand in for the trim converter view
module tic_loader_bench
	import tic_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic        por_done = 1'b0, lock_override = 1'b0;
	logic [7:0]  lock_val = 8'hFF, temp_val = 8'h30, ee_rdata, temp_code;
	logic        hreadyout, hresp, ee_rd, ee_rvalid, temp_start, temp_done;
	logic        fb_internal_sel, busy;
	logic [9:0]  ee_addr;
	tic_cal_type cal;
	int          fails = 0, tests_run = 0;
	logic [7:0]  codes [6] = '{8'h00, 8'h7F, 8'h80, 8'hAF, 8'hC8, 8'hFF};
	always #10 clk = ~clk;
	tic_loader #(.TICK_CYCLES(16'h00C8)) u_tic_loader (.clk, .srst, .hsel,
		.haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
		.hreadyout, .hresp, .hrdata, .por_done, .lock_override, .ee_rd,
		.ee_addr, .ee_rdata, .ee_rvalid, .temp_start, .temp_code,
		.temp_done, .cal, .fb_internal_sel, .busy);
	tic_mem_model u_tic_mem_model (.clk, .lock_val, .temp_val, .ee_rd,
		.ee_addr, .ee_rdata, .ee_rvalid, .temp_start, .temp_code, .temp_done);
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, s);
		tests_run++;
		if (s !== e)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	// edges until ready is sampled high, bounded
	task automatic ready_edge();
		int k;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (hreadyout !== 1'b1 && k < 20);
		if (hreadyout !== 1'b1)
		begin
			fails++;
			$display("[FAIL] hready expected 1 seen %b", hreadyout);
			tally_and_finish();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		ready_edge();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {16'h0, d};
		ready_edge();
		rd = hrdata;
		chk("hresp", 16'h0, {15'h0, hresp});
	endtask
	task automatic wait_load();
		int k;
		k = 0;
		while (busy !== 1'b1 && k < 400)
		begin
			@(posedge clk);
			k++;
		end
		if (busy !== 1'b1)
		begin
			fails++;
			$display("[FAIL] load start expected busy 1 seen %b", busy);
			tally_and_finish();
		end
		while (busy !== 1'b0 && k < 800)
		begin
			@(posedge clk);
			k++;
		end
		if (k >= 800)
		begin
			fails++;
			$display("[FAIL] load end expected busy 0 seen %b", busy);
			tally_and_finish();
		end
		@(posedge clk);
	endtask
	// word image: high byte is low byte with bit 0 flipped
	function automatic logic [15:0] wd(input logic [9:0] a);
		logic [7:0] lo;
		lo = a[7:0] ^ {a[9:8], 6'h15};
		return {lo ^ 8'h01, lo};
	endfunction
	task automatic check_load(input logic [7:0] code);
		logic [7:0]  ci;
		logic [15:0] s;
		ci = (code > 8'hAF) ? 8'hAF : code;
		s = wd(ci < 8'h80 ? {2'b10, ci[6:0], 1'b0} :
			10'h1A0 + {1'b0, ci - 8'h80, 1'b0});
		chk("setup", wd(10'h160), cal.setup);
		chk("off_drift", wd(10'h164), cal.offset_drift_coeff_reg);
		chk("span_drift", wd(10'h168), cal.span_drift_coeff_reg);
		chk("span_trim", s, cal.span_trim_reg);
		s = wd(10'h160);
		chk("fb_sel", {15'h0, s[0]}, {15'h0, fb_internal_sel});
		bus(1'b0, TIC_REG_OFF_TRIM, 16'h0);
		chk("off_trim", wd({1'b0, ci, 1'b0}), rd[15:0]);
		chk("upper", 16'h0, rd[31:16]);
	endtask
	initial
	begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		por_done <= 1'b1;
		wait_load();
		check_load(8'h30);
		foreach (codes[i])
		begin
			temp_val <= codes[i];
			wait_load();
			check_load(codes[i]);
		end
		bus(1'b1, TIC_REG_SPAN_TRIM, 16'h1234);
		@(posedge clk);
		chk("locked_write", wd(10'h1FE), cal.span_trim_reg);
		lock_override <= 1'b1;
		@(posedge clk);
		bus(1'b1, TIC_REG_OFF_TRIM, 16'hFFFF);
		bus(1'b1, TIC_REG_SPAN_TRIM, 16'h0000);
		wait_load();
		bus(1'b0, TIC_REG_OFF_TRIM, 16'h0);
		chk("serial_max", 16'hFFFF, rd[15:0]);
		chk("serial_min", 16'h0000, cal.span_trim_reg);
		bus(1'b0, 8'h40, 16'h0);
		chk("unmapped", 16'h0, rd[15:0]);
		lock_override <= 1'b0;
		lock_val <= 8'h00;
		wait_load();
		bus(1'b1, TIC_REG_OFF_DRIFT, 16'h5A5A);
		wait_load();
		chk("lock_open", 16'h5A5A, cal.offset_drift_coeff_reg);
		bus(1'b0, TIC_REG_STATUS, 16'h0);
		chk("status_lo", 16'h0004, rd[15:0]);
		chk("status_hi", 16'h00AF, rd[31:16]);
		tally_and_finish();
	end
endmodule // tic_loader_bench
